// ===== inc/fsr_pkg.sv
/*
 * Package for the flash status poller: register map of the poller's own
 * registers, command codes, pin bundles and bus timing counts.
 * Assumes a 10 MHz system clock and one parallel flash on the pins.
 */
package fsr_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses on AHB-Lite)
    // ------------------------------------------------------------
    localparam logic [7:0] FSR_CTRL_OFS = 8'h00;
    localparam logic [7:0] FSR_ADDR_OFS = 8'h04;
    localparam logic [7:0] FSR_DATA_OFS = 8'h08;
    localparam logic [7:0] FSR_STAT_OFS = 8'h0C;
    localparam logic [7:0] FSR_LAST_OFS = 8'h10;
    // Control word fields
    localparam int FSR_CTRL_CMD_LSB = 0;
    localparam int FSR_CTRL_GO_BIT = 8;
    localparam int FSR_CTRL_MODE_BIT = 9;
    // Status word fields
    localparam int FSR_ST_BUSY_BIT = 0;
    localparam int FSR_ST_DONE_BIT = 1;
    localparam int FSR_ST_FAIL_BIT = 2;
    localparam int FSR_ST_SUSP_BIT = 3;
    localparam int FSR_ST_RDY_BIT = 4;
    // Controller commands
    localparam logic [1:0] FSR_CMD_WRITE = 2'h0;
    localparam logic [1:0] FSR_CMD_READ = 2'h1;
    localparam logic [1:0] FSR_CMD_POLL = 2'h2;
    // Flash command that returns the part to array reads
    localparam logic [7:0] FSR_RESET_CMD = 8'hF0;
    // Flash data bit positions used in status
    localparam int FSR_POLL_BIT = 7;
    localparam int FSR_TOGGLE_BIT = 6;
    localparam int FSR_FAIL_BIT = 5;
    localparam int FSR_SECTOR_BIT = 2;
    // Bus cycle strobe width
    localparam int FSR_CLK_NS = 100;
    localparam int FSR_STROBE_NS = 200;
    localparam int FSR_STROBE_CYC = (FSR_STROBE_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
    localparam logic [3:0] FSR_STROBE_CNT = 4'(FSR_STROBE_CYC);

    // Pins driven to the flash
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [19:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
    } fsr_pins_t;

    typedef enum logic [2:0] {
        FSR_IDLE = 3'b000,
        FSR_WR = 3'b001,
        FSR_RD = 3'b010,
        FSR_GAP = 3'b011,
        FSR_JUDGE = 3'b100
    } fsr_state_t;
endpackage

// ===== hdl/fsr_poller.sv
/*
 * Flash status poller: AHB-Lite slave that issues single write and read
 * cycles to a parallel flash and runs toggle polling on its status bits.
 * Assumes the flash pins are wired by the bench; ready/busy is pulled up
 * outside and arrives asynchronously.
 */
// Operation
// - Poll program status at programmed address
// - Poll erase status inside selected sector
// - After bit 7 true, take next read; the poller never checks bit 7 and always takes the second read
// - Two reads compare toggle bit first
// - Toggling with bit 5 high: recheck, fail
// - Resumed polling restarts at double read
// - After timeout the host writes reset
// - Reset command is F0 to any address
`timescale 1ns/100ps
module fsr_poller (
    // System
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Flash pins
    output fsr_pkg::fsr_pins_t flash_o,
    input wire logic [7:0] flash_dq_in,
    input wire logic ready_busy_n
);
    import fsr_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [8:0] sync1_reg, sync2_reg;
    // Two flops: data bus and ready/busy are asynchronous to hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
        end else begin
            sync1_reg <= {ready_busy_n, flash_dq_in};
            sync2_reg <= sync1_reg;
        end
    end
    logic [7:0] dq_s;
    logic rdy_s;
    assign dq_s = sync2_reg[7:0];
    assign rdy_s = sync2_reg[8];

    // ------------------------------------------------------------
    // AHB-Lite slave registers
    // ------------------------------------------------------------
    logic ph_wr_reg, ph_wr_next;
    logic ph_rd_reg, ph_rd_next;
    logic [7:0] ph_ofs_reg, ph_ofs_next;
    logic [19:0] addr_reg, addr_next;
    logic [7:0] wdat_reg, wdat_next;
    logic [1:0] cmd_reg, cmd_next;
    logic go_pulse;
    logic [31:0] rdata_reg, rdata_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic fail_reg, fail_next;
    logic susp_reg, susp_next;
    logic [7:0] last_reg, last_next;
    logic done_set, fail_set, susp_set;

    function automatic logic [31:0] fsr_status(input logic b, input logic d, input logic f,
                                               input logic s, input logic r);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[FSR_ST_BUSY_BIT] = b;
        w[FSR_ST_DONE_BIT] = d;
        w[FSR_ST_FAIL_BIT] = f;
        w[FSR_ST_SUSP_BIT] = s;
        w[FSR_ST_RDY_BIT] = r;
        return w;
    endfunction

    // Bus decode, register writes and read data
    always_comb begin
        ph_wr_next = 1'b0;
        ph_rd_next = 1'b0;
        ph_ofs_next = ph_ofs_reg;
        addr_next = addr_reg;
        wdat_next = wdat_reg;
        cmd_next = cmd_reg;
        go_pulse = 1'b0;
        rdata_next = rdata_reg;
        done_next = done_reg;
        fail_next = fail_reg;
        susp_next = susp_reg;
        if (hsel && hready && htrans[1]) begin
            ph_wr_next = hwrite;
            ph_rd_next = !hwrite;
            ph_ofs_next = haddr[7:0];
        end
        if (ph_wr_reg) begin
            unique case (ph_ofs_reg)
                FSR_CTRL_OFS: begin
                    // Starting a new order clears old results; a new poll restarts fresh
                    cmd_next = hwdata[FSR_CTRL_CMD_LSB +: 2];
                    go_pulse = hwdata[FSR_CTRL_GO_BIT] && !busy_reg;
                    if (go_pulse) begin
                        done_next = 1'b0;
                        fail_next = 1'b0;
                        susp_next = 1'b0;
                    end
                end
                FSR_ADDR_OFS: addr_next = hwdata[19:0];
                FSR_DATA_OFS: wdat_next = hwdata[7:0];
                default: ;
            endcase
        end
        // Set wins over any clear in the same cycle
        if (done_set) done_next = 1'b1;
        if (fail_set) fail_next = 1'b1;
        if (susp_set) susp_next = 1'b1;
        if (ph_rd_reg) begin
            unique case (ph_ofs_reg)
                FSR_ADDR_OFS: rdata_next = {12'h000, addr_reg};
                FSR_DATA_OFS: rdata_next = {24'h000000, wdat_reg};
                FSR_STAT_OFS: rdata_next = fsr_status(busy_reg, done_reg, fail_reg, susp_reg, rdy_s);
                FSR_LAST_OFS: rdata_next = {24'h000000, last_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_reg <= 1'b0;
            ph_rd_reg <= 1'b0;
            ph_ofs_reg <= 8'h00;
            addr_reg <= 20'h00000;
            wdat_reg <= 8'h00;
            cmd_reg <= 2'h0;
            rdata_reg <= 32'h0000_0000;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            susp_reg <= 1'b0;
        end else begin
            ph_wr_reg <= ph_wr_next;
            ph_rd_reg <= ph_rd_next;
            ph_ofs_reg <= ph_ofs_next;
            addr_reg <= addr_next;
            wdat_reg <= wdat_next;
            cmd_reg <= cmd_next;
            rdata_reg <= rdata_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
            susp_reg <= susp_next;
        end
    end

    // Read data is registered, so a read answers with one wait state
    assign hreadyout = !ph_rd_reg;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    // ------------------------------------------------------------
    // Flash cycle sequencer
    // ------------------------------------------------------------
    fsr_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [1:0] nrd_reg, nrd_next;
    logic [7:0] prev_reg, prev_next;
    logic recheck_reg, recheck_next;
    fsr_pins_t pins_reg, pins_next;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        nrd_next = nrd_reg;
        prev_next = prev_reg;
        recheck_next = recheck_reg;
        pins_next = pins_reg;
        busy_next = busy_reg;
        last_next = last_reg;
        done_set = 1'b0;
        fail_set = 1'b0;
        susp_set = 1'b0;
        unique case (st_reg)
            FSR_IDLE: begin
                pins_next = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: addr_reg, dq_out: wdat_reg,
                              dq_oe: 1'b0};
                if (go_pulse) begin
                    busy_next = 1'b1;
                    cnt_next = FSR_STROBE_CNT;
                    nrd_next = 2'h0;
                    recheck_next = 1'b0;
                    if (cmd_next == FSR_CMD_WRITE) begin
                        st_next = FSR_WR;
                        pins_next.ce_n = 1'b0;
                        pins_next.we_n = 1'b0;
                        pins_next.dq_oe = 1'b1;
                    end else begin
                        st_next = FSR_RD;
                        pins_next.ce_n = 1'b0;
                        pins_next.oe_n = 1'b0;
                    end
                end
            end
            FSR_WR: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    // status valid after this rising edge
                    pins_next.we_n = 1'b1;
                    pins_next.ce_n = 1'b1;
                    st_next = FSR_GAP;
                end
            end
            FSR_RD: begin
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end
                if (cnt_reg == 4'h1) begin
                    // Strobes rise after the full width
                    pins_next.oe_n = 1'b1;
                    pins_next.ce_n = 1'b1;
                end
                if (cnt_reg == 4'h0) begin
                    // Two-flop lag: the strobed byte reaches dq_s at the release edge and is taken one cycle later
                    last_next = dq_s;
                    st_next = (cmd_reg == FSR_CMD_POLL) ? FSR_JUDGE : FSR_GAP;
                end
            end
            FSR_JUDGE: begin
                if (nrd_reg == 2'h0) begin
                    prev_next = last_reg;
                    nrd_next = 2'h1;
                    st_next = FSR_GAP;
                end else if (last_reg[FSR_TOGGLE_BIT] == prev_reg[FSR_TOGGLE_BIT]) begin
                    done_set = 1'b1;
                    // sector bit still toggling means suspended
                    if (last_reg[FSR_SECTOR_BIT] != prev_reg[FSR_SECTOR_BIT]) susp_set = 1'b1;
                    busy_next = 1'b0;
                    st_next = FSR_GAP;
                end else if (recheck_reg) begin
                    // still toggling after bit 5 high
                    // software must now issue the reset write
                    fail_set = 1'b1;
                    busy_next = 1'b0;
                    st_next = FSR_GAP;
                end else begin
                    // bit 5 high forces one recheck
                    recheck_next = last_reg[FSR_FAIL_BIT];
                    prev_next = last_reg;
                    st_next = FSR_GAP;
                end
            end
            FSR_GAP: begin
                pins_next.dq_oe = 1'b0;
                if (cmd_reg == FSR_CMD_POLL && busy_reg) begin
                    st_next = FSR_RD;
                    cnt_next = FSR_STROBE_CNT;
                    pins_next.ce_n = 1'b0;
                    pins_next.oe_n = 1'b0;
                end else begin
                    if (cmd_reg != FSR_CMD_POLL) done_set = 1'b1;
                    busy_next = 1'b0;
                    st_next = FSR_IDLE;
                end
            end
            default: st_next = FSR_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= FSR_IDLE;
            cnt_reg <= 4'h0;
            nrd_reg <= 2'h0;
            prev_reg <= 8'h00;
            recheck_reg <= 1'b0;
            pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h00000, dq_out: 8'h00, dq_oe: 1'b0};
            busy_reg <= 1'b0;
            last_reg <= 8'h00;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            nrd_reg <= nrd_next;
            prev_reg <= prev_next;
            recheck_reg <= recheck_next;
            pins_reg <= pins_next;
            busy_reg <= busy_next;
            last_reg <= last_next;
        end
    end

    assign flash_o = pins_reg;
endmodule

// ===== tb/fsr_poller_monitor.sv
/*
 * Checker for the flash status poller: bus answer timing and flash strobe rules.
 * Assumes it is bound to fsr_poller and sees only that module's ports.
 */
`timescale 1ns/100ps
module fsr_poller_monitor (
    // System
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Flash pins
    input wire fsr_pkg::fsr_pins_t flash_o
);
    import fsr_pkg::*;
    logic take;
    // Address phase accepted at this edge
    assign take = hsel && hready && htrans[1];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_NO_ERROR: assert property (hresp == 1'b0)
        else $error("error response seen");
    AST_WR_NO_WAIT: assert property (take && hwrite |=> hreadyout)
        else $error("write got wait states");
    AST_RD_ONE_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read not answered after one wait");
    AST_STROBE_EXCL: assert property (!(flash_o.oe_n == 1'b0 && flash_o.we_n == 1'b0))
        else $error("read and write strobes low together");
    AST_WR_DRIVES: assert property (!flash_o.we_n |-> flash_o.dq_oe && !flash_o.ce_n)
        else $error("write strobe without data drive");
    AST_RD_RELEASES: assert property (!flash_o.oe_n |-> !flash_o.dq_oe && !flash_o.ce_n)
        else $error("read strobe while driving data");
    AST_WE_WIDTH: assert property ($fell(flash_o.we_n) |-> ##1 !flash_o.we_n ##1 flash_o.we_n)
        else $error("write strobe not two cycles");
    AST_OE_WIDTH: assert property ($fell(flash_o.oe_n) |-> ##1 !flash_o.oe_n ##1 flash_o.oe_n)
        else $error("read strobe not two cycles");
    AST_ADDR_HELD: assert property (!flash_o.ce_n && $past(flash_o.ce_n) == 1'b0 |-> $stable(flash_o.addr))
        else $error("address moved during a cycle");
    AST_DATA_HELD: assert property (!flash_o.we_n && $past(flash_o.we_n) == 1'b0 |-> $stable(flash_o.dq_out))
        else $error("write data moved during strobe");
    // Main scenarios reached
    COV_WRITE: cover property ($fell(flash_o.we_n));
    COV_READ: cover property ($fell(flash_o.oe_n));
    COV_BUS_READ: cover property (take && !hwrite);
endmodule
bind fsr_poller fsr_poller_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .flash_o(flash_o));

// ===== tb/fsr_flash_model.sv
/*
 * Behavioural parallel flash: reports program status on its data bits.
 * Assumes strobes from the poller; ready/busy is driven both high and low here from the busy flag.
 */
`timescale 1ns/100ps
module fsr_flash_model (
    // Pins from the controller
    input wire fsr_pkg::fsr_pins_t pins,
    // Scenario: 0 completes, 1 times out, 2 erase-suspended, 3 protected target
    input wire logic [1:0] mode,
    input wire logic [3:0] busy_reads,
    // Pins back to the controller
    output logic [7:0] dq,
    output logic rb_n,
    output logic [7:0] last_wr
);
    import fsr_pkg::*;
    logic busy, susp, fail, t6, t2, wr_sel;
    logic [3:0] left;
    logic [7:0] data, rd_val;
    initial begin
        {busy, susp, fail, t6, t2} = 5'h00;
        left = 4'h0;
        data = 8'hFF;
        last_wr = 8'h00;
        wr_sel = 1'b0;
    end
    // Select and write strobe rise together, so the select is noted at the fall
    always @(negedge pins.we_n) begin
        wr_sel = !pins.ce_n;
    end
    // byte latched at write strobe rise; F0 returns to array
    always @(posedge pins.we_n) begin
        if (wr_sel) begin
            last_wr = pins.dq_out;
            if (pins.dq_out == FSR_RESET_CMD) begin
                {busy, susp, fail} = 3'h0;
            end else begin
                if (mode != 2'h3) data = pins.dq_out;
                busy = (mode != 2'h2);
                susp = (mode == 2'h2);
                fail = 1'b0;
                left = busy_reads;
            end
        end
    end
    // status advances at each read end
    always @(posedge pins.oe_n) begin
        t6 = busy ? ~t6 : t6;
        t2 = susp ? ~t2 : t2;
        if (busy && left != 4'h0) begin
            left = left - 4'h1;
        end else if (busy && (mode == 2'h0 || mode == 2'h3)) begin
            busy = 1'b0;
        end else if (busy) begin
            fail = 1'b1;
        end
    end
    // status replaces array data; released bus shows the inverse
    assign rd_val = busy ? {~data[7], t6, fail, 5'h00} : (susp ? {1'b1, t6, 3'h0, t2, 2'h0} : data);
    assign dq = (!pins.ce_n && !pins.oe_n) ? rd_val : ~rd_val;
    assign rb_n = !busy;
endmodule

// ===== tb/testbench.sv
/*
 * Self-checking bench for the flash status poller over AHB-Lite.
 * Assumes the flash model on the pins and the bound checker.
 */
`timescale 1ns/100ps
module testbench;
    import fsr_pkg::*;
    logic hclk, hresetn, hsel, hwrite;
    logic [1:0] htrans, mode;
    logic [2:0] hsize;
    logic [3:0] nreads;
    logic [31:0] haddr, hwdata, st;
    wire logic hreadyout, hresp, rb_n;
    wire logic [31:0] hrdata;
    wire logic [7:0] dq, last_wr;
    fsr_pins_t pins;
    int mismatches, compares, cycles;
    fsr_poller i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .flash_o(pins), .flash_dq_in(dq), .ready_busy_n(rb_n));
    fsr_flash_model i_flash (.pins(pins), .mode(mode), .busy_reads(nreads), .dq(dq), .rb_n(rb_n),
        .last_wr(last_wr));
    // ------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // Whole run needs a few hundred cycles; a hang ends here
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            stop_test();
        end
    end
    task stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    // Ready is looked at half a cycle early so no edge race decides it
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        logic ok;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        ok = 1'b0;
        while (!ok) begin
            @(negedge hclk);
            ok = (hreadyout === 1'b1);
            @(posedge hclk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        ok = 1'b0;
        while (!ok) begin
            @(negedge hclk);
            ok = (hreadyout === 1'b1);
            rd = hrdata;
            @(posedge hclk);
        end
    endtask
    // Start a command and poll busy until it clears
    task run(input logic [1:0] cmd, output logic [31:0] s);
        xfer(1'b1, FSR_CTRL_OFS, 32'h00000100 | 32'(cmd), s);
        s = 32'h00000001;
        for (int i = 0; i < 200 && s[FSR_ST_BUSY_BIT] !== 1'b0; i++)
            xfer(1'b0, FSR_STAT_OFS, 32'h00000000, s);
    endtask
    task start_op(input logic [1:0] m, input logic [7:0] d);
        mode <= m;
        nreads <= 4'h3;
        xfer(1'b1, FSR_ADDR_OFS, 32'h00000123, st);
        xfer(1'b1, FSR_DATA_OFS, 32'(d), st);
        run(FSR_CMD_WRITE, st);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs();
        xfer(1'b0, FSR_STAT_OFS, 32'h00000000, st);
        check(st, 32'h00000010);
        xfer(1'b0, 8'h20, 32'h00000000, st);
        check(st, 32'h00000000);
        xfer(1'b1, FSR_ADDR_OFS, 32'h0005A5A5, st);
        xfer(1'b0, FSR_ADDR_OFS, 32'h00000000, st);
        check(st, 32'h0005A5A5);
    endtask
    task t_prog();
        start_op(2'h0, 8'hA5);
        check(st & 32'h0000001F, 32'h00000002);
        run(FSR_CMD_READ, st);
        xfer(1'b0, FSR_LAST_OFS, 32'h00000000, st);
        check(32'(st[7]), 32'h00000000);
        run(FSR_CMD_POLL, st);
        check(st & 32'h0000001F, 32'h00000012);
        run(FSR_CMD_READ, st);
        xfer(1'b0, FSR_LAST_OFS, 32'h00000000, st);
        check(st, 32'h000000A5);
    endtask
    task t_fail();
        start_op(2'h1, 8'h3C);
        run(FSR_CMD_POLL, st);
        check(st & 32'h00000005, 32'h00000004);
        xfer(1'b1, FSR_DATA_OFS, 32'h000000F0, st);
        run(FSR_CMD_WRITE, st);
        check(32'(last_wr), 32'h000000F0);
        run(FSR_CMD_READ, st);
        xfer(1'b0, FSR_LAST_OFS, 32'h00000000, st);
        check(st, 32'h0000003C);
    endtask
    task t_susp();
        start_op(2'h2, 8'h5A);
        check(st & 32'h00000010, 32'h00000010);
        run(FSR_CMD_POLL, st);
        check(st & 32'h0000001E, 32'h0000001A);
    endtask
    // Protected target: the array keeps the byte written in the suspend scenario
    task t_prot();
        start_op(2'h3, 8'h00);
        check(st & 32'h0000001F, 32'h00000002);
        run(FSR_CMD_POLL, st);
        check(st & 32'h0000001F, 32'h00000012);
        run(FSR_CMD_READ, st);
        xfer(1'b0, FSR_LAST_OFS, 32'h00000000, st);
        check(st, 32'h0000005A);
    endtask
    initial begin
        {hresetn, hsel, hwrite} = 3'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        mode = 2'h0;
        nreads = 4'h3;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_prog();
        t_fail();
        t_susp();
        t_prot();
        stop_test();
    end
endmodule
